/* File: core/cid_params.svh */
// constants for the instruction decode and execute core
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH
`define CID_CLK_NS 25
`define CID_FMT_BYTE 2'h0
`define CID_FMT_BIT 2'h1
`define CID_FMT_JUMP 2'h2
`define CID_FMT_LIT 2'h3
`define CID_OP_STORE 4'h0
`define CID_OP_CLR 4'h1
`define CID_OP_SUB 4'h2
`define CID_OP_DEC 4'h3
`define CID_OP_IOR 4'h4
`define CID_OP_AND 4'h5
`define CID_OP_XOR 4'h6
`define CID_OP_ADD 4'h7
`define CID_OP_MOVE 4'h8
`define CID_OP_COM 4'h9
`define CID_OP_INC 4'ha
`define CID_OP_DECSZ 4'hb
`define CID_OP_ROR 4'hc
`define CID_OP_ROL 4'hd
`define CID_OP_SWAP 4'he
`define CID_OP_INCSZ 4'hf
`define CID_CW_RETURN 7'h08
`define CID_CW_IRET 7'h09
`define CID_CW_SLEEP 7'h63
`define CID_CW_KICK 7'h64
`define CID_NOP_MASK 7'h1f
`define CID_LIT_ANDL 4'h9
`define CID_LIT_IORL 4'h8
`define CID_LIT_XORL 4'ha
`define CID_TIMER0_ADDR 7'h01
`define CID_WB_OFS_CTRL 4'h0
`define CID_WB_OFS_ACC 4'h4
`define CID_WB_OFS_FLAGS 4'h8
`define CID_WB_OFS_PC 4'hc
`define CID_PC_RESET 13'h0000
`endif

/* File: core/cid_pkg.sv */
// types shared by the instruction decode and execute core
package cid_pkg;
    typedef enum logic [1:0] {
        CID_RUN,
        CID_FLUSH,
        CID_HALT
    } cid_state_t;
endpackage

/* File: core/cid_core.sv */
// instruction decode and execute core for a 14-bit instruction word
// Operation
// [RULE1] byte format: 00, opcode, d, 7-bit file
// [RULE2] d=0 result to acc, d=1 to file
// [RULE3] add and subtract update carry, nibble, zero
// [RULE4] and, or, xor affect only zero
// [RULE5] complement, decrement, increment update only zero
// [RULE6] rotates through carry change only carry
// [RULE7] clear file or acc, set zero
// [RULE8] dec/inc skip on zero, no flags
// [RULE9] bit format: clear or set selected bit
// [RULE10] bit tests skip next instruction, two cycles
// [RULE11] literal add and subtract update carry flags
// [RULE12] literal and, or, xor affect only zero
// [RULE13] literal load; return loading literal pops
// [RULE14] call pushes next address, loads pc
// [RULE15] jump absolute loads pc, no stack
// [RULE16] returns pop stack top into pc
// [RULE17] watchdog kick clears counter, sets both flags
// [RULE18] standby-entry decoded, one cycle
// [RULE19] pc change or true test: two cycles
// [RULE20] port read-modify-write uses pin levels
// [RULE21] write to timer zero clears prescaler; the code clears it only while presc_on_timer0_i is set
// [RULE22] move file sets zero; store acc no flags
// [RULE23] swap halves, no flag change
// [RULE24] interrupt return sets global irq enable
// [RULE25] standby clears powerdown, sets expired, halts
// [RULE26] no-operation pattern changes nothing
// [RULE27] don't-care bits ignored
`timescale 1ns/1ps
`include "cid_params.svh"
module cid_core
    import cid_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // program memory
    output logic [12:0] prog_addr_o,
    input wire logic [13:0] prog_data_i,
    // file register side (same clock domain)
    output logic [6:0] file_addr_o,
    input wire logic [7:0] file_rdata_i,
    input wire logic file_is_port_i,
    input wire logic [7:0] port_pins_i,
    output logic file_we_o,
    output logic [7:0] file_wdata_o,
    // stack and upper latch
    input wire logic [12:0] stack_top_i,
    output logic stack_push_o,
    output logic stack_pop_o,
    output logic [12:0] stack_push_data_o,
    input wire logic [4:0] prog_counter_upper_latch_i,
    // side effects
    output logic global_irq_enable_set_o,
    output logic watchdog_clear_o,
    output logic timer0_presc_clear_o,
    input wire logic presc_on_timer0_i,
    output logic osc_stop_o,
    input wire logic wake_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    cid_state_t state_r;
    logic [12:0] program_counter_r;
    logic [7:0] acc_r;
    logic carry_r, nibble_overflow_bit_r, zero_r;
    logic powerdown_flag_r, watchdog_expired_flag_r;
    logic run_en_r;
    logic [1:0] wake_sync_r;
    logic [13:0] ir;
    logic [3:0] op;
    logic dst;
    logic [7:0] fval, bmask, res, lit;
    logic [8:0] sum;
    logic [4:0] nib;
    logic wr_acc, wr_file, upd_z, upd_c, upd_dc, new_c, new_dc, skip;
    logic pc_load, push, pop, ien, kick, sleep_op;
    logic [12:0] pc_tgt;
    logic step, jmp_r;

    // adder shared by add and subtract forms
    function automatic logic [8:0] add9(input logic [7:0] a, b,
                                         input logic cin);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    assign step = clk_en_i && run_en_r && state_r != CID_HALT;
    assign ir = prog_data_i;
    assign op = ir[11:8];
    assign dst = ir[7];
    assign lit = ir[7:0];
    assign prog_addr_o = program_counter_r;
    assign file_addr_o = ir[6:0]; // [RULE1]
    // port rmw reads the pins, not the latch [RULE20]
    assign fval = file_is_port_i ? port_pins_i : file_rdata_i;
    assign bmask = 8'h01 << ir[9:7]; // [RULE9]

    always_comb begin
        res = 8'h00;
        sum = 9'h000;
        nib = 5'h00;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        new_c = carry_r;
        new_dc = nibble_overflow_bit_r;
        skip = 1'b0;
        pc_load = 1'b0;
        pc_tgt = program_counter_r;
        push = 1'b0;
        pop = 1'b0;
        ien = 1'b0;
        kick = 1'b0;
        sleep_op = 1'b0;
        case (ir[13:12])
            `CID_FMT_BYTE: begin
                wr_acc = !dst; // [RULE2]
                wr_file = dst; // [RULE2]
                case (op)
                    `CID_OP_STORE: begin
                        wr_acc = 1'b0;
                        wr_file = 1'b0;
                        if (dst) begin
                            res = acc_r; // [RULE22]
                            wr_file = 1'b1;
                        end else if (ir[6:0] == `CID_CW_RETURN ||
                                     ir[6:0] == `CID_CW_IRET) begin
                            pop = 1'b1; // [RULE16]
                            pc_load = 1'b1;
                            pc_tgt = stack_top_i;
                            ien = ir[0]; // [RULE24]
                        end else if (ir[6:0] == `CID_CW_KICK) begin
                            kick = 1'b1; // [RULE17]
                        end else if (ir[6:0] == `CID_CW_SLEEP) begin
                            sleep_op = 1'b1; // [RULE18]
                        end
                        // 0xx0_0000 and other codes fall through [RULE26]
                    end
                    `CID_OP_CLR: begin
                        res = 8'h00; // [RULE7]
                        upd_z = 1'b1;
                    end
                    `CID_OP_SUB, `CID_OP_ADD: begin
                        sum = (op == `CID_OP_ADD) ?
                            add9(fval, acc_r, 1'b0) :
                            add9(fval, ~acc_r, 1'b1); // [RULE3]
                        nib = (op == `CID_OP_ADD) ?
                            {1'b0, fval[3:0]} + {1'b0, acc_r[3:0]} :
                            {1'b0, fval[3:0]} + {1'b0, ~acc_r[3:0]}
                                + 5'h01;
                        res = sum[7:0];
                        {upd_z, upd_c, upd_dc} = 3'b111;
                        new_c = sum[8];
                        new_dc = nib[4];
                    end
                    `CID_OP_AND: begin
                        res = acc_r & fval; // [RULE4]
                        upd_z = 1'b1;
                    end
                    `CID_OP_IOR: begin
                        res = acc_r | fval; // [RULE4]
                        upd_z = 1'b1;
                    end
                    `CID_OP_XOR: begin
                        res = acc_r ^ fval; // [RULE4]
                        upd_z = 1'b1;
                    end
                    `CID_OP_COM, `CID_OP_DEC, `CID_OP_INC: begin
                        res = (op == `CID_OP_COM) ? ~fval :
                            (op == `CID_OP_DEC) ? fval - 8'h01 :
                            fval + 8'h01; // [RULE5]
                        upd_z = 1'b1;
                    end
                    `CID_OP_DECSZ, `CID_OP_INCSZ: begin
                        res = (op == `CID_OP_DECSZ) ? fval - 8'h01 :
                            fval + 8'h01;
                        skip = (res == 8'h00); // [RULE8]
                    end
                    `CID_OP_ROL: begin
                        res = {fval[6:0], carry_r}; // [RULE6]
                        upd_c = 1'b1;
                        new_c = fval[7];
                    end
                    `CID_OP_ROR: begin
                        res = {carry_r, fval[7:1]}; // [RULE6]
                        upd_c = 1'b1;
                        new_c = fval[0];
                    end
                    `CID_OP_MOVE: begin
                        res = fval; // [RULE22]
                        upd_z = 1'b1;
                    end
                    `CID_OP_SWAP: begin
                        res = {fval[3:0], fval[7:4]}; // [RULE23]
                    end
                    default: begin
                        res = fval;
                    end
                endcase
            end
            `CID_FMT_BIT: begin
                case (ir[11:10])
                    2'h0: begin
                        res = fval & ~bmask; // [RULE9]
                        wr_file = 1'b1;
                    end
                    2'h1: begin
                        res = fval | bmask; // [RULE9]
                        wr_file = 1'b1;
                    end
                    2'h2: skip = !(|(fval & bmask)); // [RULE10]
                    default: skip = |(fval & bmask); // [RULE10]
                endcase
            end
            `CID_FMT_JUMP: begin
                pc_load = 1'b1; // [RULE15]
                pc_tgt = {prog_counter_upper_latch_i[4:3], ir[10:0]};
                push = !ir[11]; // [RULE14]
            end
            default: begin
                wr_acc = 1'b1;
                if (ir[11:9] == 3'h7 || ir[11:9] == 3'h6) begin
                    // bit 8 is a don't-care here [RULE27]
                    sum = ir[9] ? add9(lit, acc_r, 1'b0) :
                        add9(lit, ~acc_r, 1'b1); // [RULE11]
                    nib = ir[9] ?
                        {1'b0, lit[3:0]} + {1'b0, acc_r[3:0]} :
                        {1'b0, lit[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
                    res = sum[7:0];
                    {upd_z, upd_c, upd_dc} = 3'b111;
                    new_c = sum[8];
                    new_dc = nib[4];
                end else if (op == `CID_LIT_ANDL) begin
                    res = acc_r & lit; // [RULE12]
                    upd_z = 1'b1;
                end else if (op == `CID_LIT_IORL) begin
                    res = acc_r | lit; // [RULE12]
                    upd_z = 1'b1;
                end else if (op == `CID_LIT_XORL) begin
                    res = acc_r ^ lit; // [RULE12]
                    upd_z = 1'b1;
                end else if (ir[11:10] == 2'h1) begin
                    res = lit; // [RULE13]
                    pop = 1'b1;
                    pc_load = 1'b1;
                    pc_tgt = stack_top_i;
                end else if (ir[11:10] == 2'h0) begin
                    res = lit; // [RULE13]
                end else begin
                    wr_acc = 1'b0; // unused code 1011: no effect
                end
            end
        endcase
    end

    // flush state is the nop second cycle [RULE19]
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= CID_RUN;
            jmp_r <= 1'b0;
        end else if (clk_en_i) begin
            if (state_r == CID_HALT) begin
                if (wake_sync_r[1]) begin
                    state_r <= CID_RUN;
                end
            end else if (run_en_r) begin
                jmp_r <= pc_load;
                if (state_r == CID_FLUSH) begin
                    state_r <= CID_RUN;
                end else if (sleep_op) begin
                    state_r <= CID_HALT; // [RULE25]
                end else if (pc_load || skip) begin
                    state_r <= CID_FLUSH; // [RULE19]
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_sync_r <= 2'h0;
        end else if (clk_en_i) begin
            wake_sync_r <= {wake_sync_r[0], wake_i};
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            program_counter_r <= `CID_PC_RESET;
        end else if (step) begin
            if (state_r == CID_RUN && pc_load) begin
                program_counter_r <= pc_tgt; // [RULE15]
            end else if (state_r != CID_FLUSH || !jmp_r) begin
                program_counter_r <= program_counter_r + 13'h0001;
            end
        end
    end

    // flush cycle fetches the discarded word and executes nothing
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_r <= 8'h00;
            carry_r <= 1'b0;
            nibble_overflow_bit_r <= 1'b0;
            zero_r <= 1'b0;
        end else if (step && state_r == CID_RUN) begin
            if (wr_acc) begin
                acc_r <= res; // [RULE2]
            end
            if (upd_z) begin
                zero_r <= (res == 8'h00); // [RULE7]
            end
            if (upd_c) begin
                carry_r <= new_c; // [RULE3]
            end
            if (upd_dc) begin
                nibble_overflow_bit_r <= new_dc;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            powerdown_flag_r <= 1'b1;
            watchdog_expired_flag_r <= 1'b1;
        end else if (step && state_r == CID_RUN) begin
            if (kick) begin
                powerdown_flag_r <= 1'b1; // [RULE17]
                watchdog_expired_flag_r <= 1'b1;
            end else if (sleep_op) begin
                powerdown_flag_r <= 1'b0; // [RULE25]
                watchdog_expired_flag_r <= 1'b1;
            end
        end
    end

    always_comb begin
        file_we_o = step && state_r == CID_RUN && wr_file;
        file_wdata_o = res;
        stack_push_o = step && state_r == CID_RUN && push; // [RULE14]
        stack_push_data_o = program_counter_r + 13'h0001;
        stack_pop_o = step && state_r == CID_RUN && pop; // [RULE16]
        global_irq_enable_set_o = step && state_r == CID_RUN && ien;
        watchdog_clear_o = step && state_r == CID_RUN &&
            (kick || sleep_op); // [RULE25]
        // timer zero write clears its prescaler when assigned [RULE21]
        timer0_presc_clear_o = file_we_o && presc_on_timer0_i &&
            ir[6:0] == `CID_TIMER0_ADDR;
        osc_stop_o = state_r == CID_HALT;
    end

    // wishbone: ctrl bit0 runs the core; state readable
    logic ack_r;
    logic [31:0] rdat_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
            run_en_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
            if (wb_cyc_i && wb_stb_i && !ack_r) begin
                if (wb_we_i && wb_sel_i[0] &&
                    wb_adr_i == `CID_WB_OFS_CTRL) begin
                    run_en_r <= wb_dat_i[0];
                end
                case (wb_adr_i)
                    `CID_WB_OFS_CTRL: rdat_r <= {31'h0, run_en_r};
                    `CID_WB_OFS_ACC: rdat_r <= {24'h0, acc_r};
                    `CID_WB_OFS_FLAGS: rdat_r <= {27'h0,
                        watchdog_expired_flag_r, powerdown_flag_r,
                        zero_r, nibble_overflow_bit_r, carry_r};
                    `CID_WB_OFS_PC: rdat_r <= {19'h0, program_counter_r};
                    default: rdat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_flush_after_jump;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (step && state_r == CID_RUN && pc_load) |=>
            state_r == CID_FLUSH && program_counter_r == $past(pc_tgt);
    endproperty
    a_flush_after_jump: assert property (p_flush_after_jump) // [RULE19]
        else $error("branch not followed by flush");

    property p_skip_flush;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (step && state_r == CID_RUN && skip && !pc_load) |=>
            state_r == CID_FLUSH;
    endproperty
    a_skip_flush: assert property (p_skip_flush) // [RULE10]
        else $error("skip did not discard next word");

    property p_no_write_in_flush;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        state_r == CID_FLUSH |-> !file_we_o && !stack_push_o;
    endproperty
    a_no_write_in_flush: assert property (p_no_write_in_flush) // [RULE19]
        else $error("side effect during flush cycle");

    property p_kick_flags;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (step && state_r == CID_RUN && kick) |=>
            powerdown_flag_r && watchdog_expired_flag_r;
    endproperty
    a_kick_flags: assert property (p_kick_flags) // [RULE17]
        else $error("watchdog kick flags wrong");

    property p_sleep_halt;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (step && state_r == CID_RUN && sleep_op) |=>
            !powerdown_flag_r && state_r == CID_HALT;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) // [RULE25]
        else $error("standby entry failed");

    property p_clr_zero;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (step && state_r == CID_RUN && ir[13:8] == 6'h01) |=> zero_r;
    endproperty
    a_clr_zero: assert property (p_clr_zero) // [RULE7]
        else $error("clear did not set zero");

    property p_rot_carry;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (step && state_r == CID_RUN && ir[13:8] == 6'h0d) |=>
            carry_r == $past(fval[7]) && zero_r == $past(zero_r);
    endproperty
    a_rot_carry: assert property (p_rot_carry) // [RULE6]
        else $error("rotate left carry wrong");

    property p_push_call;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        stack_push_o |-> ir[13:11] == 3'h4 &&
            stack_push_data_o == program_counter_r + 13'h0001;
    endproperty
    a_push_call: assert property (p_push_call) // [RULE14]
        else $error("bad stack push");
endmodule

/* File: test/cid_mem_model.sv */
// program memory and file registers standing beside the core
`timescale 1ns/1ps
module cid_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // core side
    input wire logic [12:0] prog_addr_i,
    output logic [13:0] prog_data_o,
    input wire logic [6:0] file_addr_i,
    output logic [7:0] file_rdata_o,
    input wire logic file_we_i,
    input wire logic [7:0] file_wdata_i,
    input wire logic stack_push_i,
    input wire logic [12:0] push_data_i,
    input wire logic [4:0] pulses_i,
    // what the core did, sticky until reset
    output logic [4:0] seen_o,
    output logic [12:0] pushed_o
);
    logic [13:0] prog_r [4];
    logic [7:0] file_r [128];
    // four words mirrored over the whole space, so any upper bits land home
    assign prog_data_o = prog_r[prog_addr_i[1:0]];
    assign file_rdata_o = file_r[file_addr_i];
    always @(posedge clk_i) begin
        if (file_we_i) begin
            file_r[file_addr_i] <= file_wdata_i;
        end
    end
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_o <= 5'h00;
            pushed_o <= 13'h0000;
        end else begin
            seen_o <= seen_o | pulses_i;
            if (stack_push_i) begin
                pushed_o <= push_data_i;
            end
        end
    end
endmodule

/* File: test/testbench.sv */
// random and corner instruction checks for the decode and execute core
`timescale 1ns/1ps
`include "cid_params.svh"
module testbench;
    logic clk, arst_n, clk_en, presc, wake, cyc, stb, we, ack, osc;
    logic push, pop, ien, wdc, tmc, is_port, we_f;
    logic [3:0] adr, sel;
    logic [31:0] dat, rdat, q;
    logic [4:0] latch, seen;
    logic [12:0] pa, pushed, push_d;
    logic [13:0] pw;
    logic [6:0] fa_o;
    logic [7:0] pins, frd, fwd;
    int errors, checks_done;
    int seed = 50018;
    // {word, acc, file}
    logic [29:0] corner [17] = '{30'h07108080, 30'h02903535, 30'h0b900001,
        30'h0f1012ff, 30'h0d100081, 30'h20030000, 30'h00090000, 30'h00630000,
        30'h00640000, 30'h00600000, 30'h3c101100, 30'h1f900080, 30'h01810055,
        30'h34550000, 30'h00080000, 30'h28030000, 30'h08850000};

    cid_core i_dut (
        .core_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(clk_en),
        .prog_addr_o(pa), .prog_data_i(pw),
        .file_addr_o(fa_o), .file_rdata_i(frd), .file_is_port_i(is_port),
        .port_pins_i(pins), .file_we_o(we_f), .file_wdata_o(fwd),
        .stack_top_i(13'h0003), .stack_push_o(push), .stack_pop_o(pop),
        .stack_push_data_o(push_d), .prog_counter_upper_latch_i(latch),
        .global_irq_enable_set_o(ien), .watchdog_clear_o(wdc),
        .timer0_presc_clear_o(tmc), .presc_on_timer0_i(presc),
        .osc_stop_o(osc), .wake_i(wake),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack)
    );
    cid_mem_model i_mem (
        .clk_i(clk), .arst_n_i(arst_n), .prog_addr_i(pa), .prog_data_o(pw),
        .file_addr_i(fa_o), .file_rdata_o(frd), .file_we_i(we_f),
        .file_wdata_i(fwd), .stack_push_i(push), .push_data_i(push_d),
        .pulses_i({push, pop, ien, wdc, tmc}), .seen_o(seen),
        .pushed_o(pushed)
    );
    // one port at file 0x05; an empty stack hands back the loop address
    assign is_port = (fa_o == 7'h05);

    task automatic stop_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            errors++;
            stop_test();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [13:0] pick(input logic [13:0] w);
        logic [13:0] cw [3] = '{14'h0008, 14'h0009, 14'h0064};
        if (w[13:12] == 2'b10) w[10:0] = 11'h003;
        if (w[13:7] == 7'h00) w = (w[1:0] == 2'h3) ? (w & 14'h0060) : cw[w[1:0]];
        if (!w[13] && w[6:0] == 7'h7f) w[6:0] = 7'h7e;
        return w;
    endfunction

    // pul: {push, pop, irq enable, watchdog clear, file written}
    function automatic void ref_exec(input logic [13:0] w,
            input logic [7:0] a, f, output logic [7:0] na, nf,
            output logic [4:0] fl, pul, output logic sk);
        logic [8:0] s;
        logic [7:0] r, y;
        logic [3:0] op;
        logic wr;
        na = a;
        nf = f;
        fl = 5'h18;
        pul = 5'h00;
        sk = 1'b0;
        y = w[13] ? w[7:0] : f;
        op = w[12] ? 4'h0 : w[11:8];
        if (w[13]) begin
            case (w[11:8])
                4'he, 4'hf: op = 4'h7;
                4'hc, 4'hd: op = 4'h2;
                4'h9: op = 4'h5;
                4'h8: op = 4'h4;
                4'ha: op = 4'h6;
                default: op = 4'h0;
            endcase
        end
        case (op)
            4'h2: r = y - a;
            4'h7: r = a + y;
            4'h3, 4'hb: r = f - 8'h01;
            4'ha, 4'hf: r = f + 8'h01;
            4'h4: r = a | y;
            4'h5: r = a & y;
            4'h6: r = a ^ y;
            4'h8: r = f;
            4'h9: r = ~f;
            4'hc: r = {1'b0, f[7:1]};
            4'hd: r = {f[6:0], 1'b0};
            4'he: r = {f[3:0], f[7:4]};
            default: r = 8'h00;
        endcase
        s = a + y;
        if (op == 4'h7) fl[1:0] = {(a[3:0] + y[3:0]) > 5'h0f, s[8]};
        if (op == 4'h2) fl[1:0] = {a[3:0] <= y[3:0], a <= y};
        if (op == 4'hc) fl[0] = f[0];
        if (op == 4'hd) fl[0] = f[7];
        wr = (w[13:12] == 2'b00 || w[13:12] == 2'b11) && op != 4'h0;
        if (wr && !(op inside {4'hb, 4'hc, 4'hd, 4'he, 4'hf})) fl[2] = r == 0;
        if (wr && op inside {4'hb, 4'hf}) sk = r == 8'h00;
        if (wr && w[7] && !w[13]) begin
            nf = r;
            pul[0] = 1'b1;
        end else if (wr) na = r;
        if (w[13:8] == 6'h00 && w[7]) begin
            nf = a;
            pul[0] = 1'b1;
        end else if (w[13:8] == 6'h00) begin
            pul[3] = w[6:0] == 7'h08 || w[6:0] == 7'h09;
            pul[2] = w[6:0] == 7'h09;
            pul[1] = w[6:0] == 7'h63 || w[6:0] == 7'h64;
            fl[3] = w[6:0] != 7'h63;
            sk = pul[3];
        end
        if (w[13:12] == 2'b01) begin
            r = f;
            r[w[9:7]] = w[10];
            if (w[11]) sk = f[w[9:7]] == w[10];
            else begin
                nf = r;
                pul[0] = 1'b1;
            end
        end
        if (w[13:12] == 2'b10) begin
            sk = 1'b1;
            pul[4] = !w[11];
        end
        if (w[13:12] == 2'b11 && !w[11]) begin
            na = w[7:0];
            sk = w[10];
            pul[3] = w[10];
        end
    endfunction

    task automatic run_case(input logic [13:0] w, input logic [7:0] a, fv);
        logic [7:0] na, nf, f, f7, p;
        logic [4:0] fl, pul;
        logic sk, hlt, pr;
        p = 8'($random(seed));
        pr = 1'($random(seed));
        arst_n <= 1'b0;
        pins <= p;
        presc <= pr;
        latch <= 5'($random(seed));
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 128; i++) i_mem.file_r[i] = 8'($random(seed));
        i_mem.file_r[w[6:0]] = fv;
        f7 = i_mem.file_r[127];
        f = (w[6:0] == 7'h05) ? p : fv;
        i_mem.prog_r[0] = {6'h30, a};
        i_mem.prog_r[1] = w;
        i_mem.prog_r[2] = 14'h00ff;
        i_mem.prog_r[3] = 14'h2803;
        ref_exec(w, a, f, na, nf, fl, pul, sk);
        hlt = (w == 14'h0063);
        wb(1'b1, `CID_WB_OFS_CTRL, 32'h1);
        wb(1'b0, `CID_WB_OFS_CTRL, 32'h0);
        chk(q, 32'h1);
        repeat (60) @(posedge clk);
        wb(1'b1, `CID_WB_OFS_CTRL, 32'h0);
        // the accumulator is read-only from the bus
        wb(1'b1, `CID_WB_OFS_ACC, 32'hff);
        wb(1'b0, `CID_WB_OFS_ACC, 32'h0);
        chk(q, {24'h0, na});
        wb(1'b0, `CID_WB_OFS_FLAGS, 32'h0);
        chk(q, {27'h0, fl});
        wb(1'b0, `CID_WB_OFS_PC, 32'h0);
        chk(q, hlt ? 32'h2 : {19'h0, latch[4:3], 11'h3});
        if (!w[13]) chk(i_mem.file_r[w[6:0]], pul[0] ? nf : fv);
        chk(i_mem.file_r[127], (sk || hlt) ? f7 : na);
        chk(seen, {pul[4:1], pul[0] && w[6:0] == 7'h01 && pr});
        if (pul[4]) chk(pushed, 13'h0002);
        chk(osc, hlt);
        wake <= 1'b1;
        repeat (16) @(posedge clk);
        chk(osc, 1'b0);
        wake <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) clk_en <= ($random(seed) & 3) != 0;

    initial begin
        #1000000;
        errors++;
        stop_test();
    end

    initial begin
        {arst_n, clk_en, presc, wake, cyc, stb, we} = 7'h00;
        {adr, sel, dat, pins, latch} = '0;
        errors = 0;
        checks_done = 0;
        @(posedge clk);
        foreach (corner[i]) run_case(corner[i][29:16], corner[i][15:8],
            corner[i][7:0]);
        repeat (80) run_case(pick(14'($random(seed))), 8'($random(seed)),
            8'($random(seed)));
        stop_test();
    end
endmodule
